// file: include/hdc_consts.svh
/*
 * Constants of the holdover DAC control block: register indices, field
 * positions, reset values and timing counts.
 * Assumes a 20 MHz hclk and word-aligned AHB-Lite register access.
 */
// Contract
// R1: control bits 7:6 pick the signal-loss timeout, lowest to highest rate.
// R2: signal-loss timeout acts only while its enable bit 5 is set.
// R3: tracking bit 4 lets the DAC code follow the first loop tuning.
// R4: after reset the tracked code starts at mid-scale 512.
// R5: tracked code moves only while the first loop is locked.
// R6: tracking works in every mode, usable as a tuning monitor.
// R7: forced-holdover bit 3 puts the block in holdover regardless of inputs.
// R8: in forced holdover, manual mode drives manual code, else tracked code.
// R9: bit 2 picks manual mode when set; defaults to manual.
// R10: manual code is ten bits, top two in control, low eight next register.
// R11: six-bit low trip, code N trips at (N+1)/64 supply from ground.
// R12: six-bit high trip, same encoding, measured from the supply.
// R13: reserved bits read zero and ignore writes.
`ifndef HDC_CONSTS_SVH
`define HDC_CONSTS_SVH

`define HDC_IDX_CTRL        10'h14b
`define HDC_IDX_MAN_LO      10'h14c
`define HDC_IDX_TRIP_LO     10'h14d
`define HDC_IDX_TRIP_HI     10'h14e
`define HDC_IDX_STATUS      10'h160
`define HDC_IDX_MASK        10'h161
`define HDC_IDX_MONITOR     10'h162
`define HDC_IDX_CONFIG      10'h163

`define HDC_CTRL_RESET      8'h06
`define HDC_MAN_LO_RESET    8'h00
`define HDC_TRIP_RESET      6'h00
`define HDC_TRACK_RESET     10'h200
`define HDC_DAC_MAX         10'h3ff
`define HDC_DAC_MIN         10'h000

`define HDC_CTRL_TMO_HI     7
`define HDC_CTRL_TMO_LO     6
`define HDC_CTRL_SIGNAL_LOSS_ENABLE     5
`define HDC_CTRL_TRACK      4
`define HDC_CTRL_FORCE      3
`define HDC_CTRL_MANUAL     2
`define HDC_CTRL_MAN_HI     1

`define HDC_ST_SWITCH       0
`define HDC_ST_HOLDOVER     1
`define HDC_ST_UNLOCK       2
`define HDC_ST_W            3

`define HDC_CLK_PS          50000
`define HDC_LOS_T0_PS       200000
`define HDC_LOS_T1_PS       40000
`define HDC_LOS_T2_PS       10000
`define HDC_LOS_T3_PS       5000
`define HDC_CYC(ps) ((((ps) / `HDC_CLK_PS) > 0) ? ((ps) / `HDC_CLK_PS) : 1)
`define HDC_LOS_W           8

`endif

// file: include/hdc_pkg.sv
/*
 * Types shared by the holdover DAC control block.
 * Assumes hdc_consts.svh provides the numeric constants.
 */
package hdc_pkg;
    typedef enum logic [1:0] {
        HDC_BUS_IDLE  = 2'b00,
        HDC_BUS_WRITE = 2'b01,
        HDC_BUS_RWAIT = 2'b10,
        HDC_BUS_RDATA = 2'b11
    } hdc_bus_state_t;

    typedef logic [9:0] hdc_code_t;
endpackage

// file: src/hdc_loss_detect.sv
/*
 * Activity watchdog for one reference input: synchronises the pin and
 * flags loss when no edge arrives within the selected count.
 * Assumes the pin is asynchronous to hclk and limit is static-ish.
 */
module hdc_loss_detect #(
    parameter int CNT_W = 8
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             pin,
    input  wire logic             enable,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  lost
);
    logic             sync1_r;
    logic             sync2_r;
    logic             prev_r;
    logic [CNT_W-1:0] cnt_r;
    logic             edge_seen;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign edge_seen = sync2_r ^ prev_r;

    // idle count since last edge, cleared while disabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
        end else if (!enable || edge_seen) begin // R2
            cnt_r <= '0;
        end else if (cnt_r < limit) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lost <= 1'b0;
        end else begin
            lost <= enable && !edge_seen && (cnt_r >= limit); // R2
        end
    end
endmodule

// file: src/hdc_top.sv
/*
 * Holdover DAC control: register file on AHB-Lite, signal-loss watchdogs,
 * tuning DAC tracking, holdover selection, trip detection and interrupt.
 * Assumes first_loop_locked and vtune_above_dac come from analog logic
 * asynchronous to hclk; ref_is_mos is static configuration on hclk.
 */
`include "hdc_consts.svh"

module hdc_top #(
    parameter int N_REF     = 3,
    parameter int TRACK_DIV = 508
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire logic [N_REF-1:0]    reference_input,
    input  wire logic [N_REF-1:0]    ref_is_mos,
    input  wire logic                first_loop_locked,
    input  wire logic                vtune_above_dac,
    output hdc_pkg::hdc_code_t       dac_code,
    output logic                     holdover_active,
    output logic [N_REF-1:0]         signal_loss,
    output logic                     clock_switch_event,
    output logic                     irq
);
    import hdc_pkg::*;

    localparam int TDIV_W = $clog2(TRACK_DIV + 1);
    localparam logic [TDIV_W-1:0] TDIV_LAST = TDIV_W'(TRACK_DIV - 1);

    hdc_bus_state_t          bus_r;
    logic [9:0]              idx_r;
    logic [31:0]             hrdata_r;
    logic                    bus_take;
    logic                    wr_stb;
    logic [31:0]             rd_val;

    logic [7:0]              ctrl_r;
    logic [7:0]              man_lo_r;
    logic [5:0]              trip_lo_r;
    logic [5:0]              trip_hi_r;
    logic [`HDC_ST_W-1:0]    status_r;
    logic [`HDC_ST_W-1:0]    mask_r;
    logic                    vtune_det_r;

    logic [1:0]              lock_sync_r;
    logic [1:0]              cmp_sync_r;
    logic                    locked;
    logic                    locked_prev_r;
    logic                    above;

    logic [TDIV_W-1:0]       tdiv_r;
    logic                    track_tick;
    hdc_code_t               track_r;
    hdc_code_t               man_code;
    hdc_code_t               dac_r;

    logic [`HDC_LOS_W-1:0]   los_limit;
    logic [N_REF-1:0]        loss_now;
    logic [N_REF-1:0]        loss_prev_r;
    logic                    switch_ev;
    logic                    switch_r;
    logic                    trip_lo;
    logic                    trip_hi;
    logic                    hold_nxt;
    logic                    hold_r;
    logic [`HDC_ST_W-1:0]    ev_set;

    // ---------------- bus slave ----------------
    assign bus_take = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_r <= HDC_BUS_IDLE;
            idx_r <= '0;
        end else begin
            case (bus_r)
                HDC_BUS_WRITE, HDC_BUS_RDATA, HDC_BUS_IDLE: begin
                    if (bus_take) begin
                        idx_r <= haddr[11:2];
                        bus_r <= hwrite ? HDC_BUS_WRITE : HDC_BUS_RWAIT;
                    end else begin
                        bus_r <= HDC_BUS_IDLE;
                    end
                end
                HDC_BUS_RWAIT: begin
                    bus_r <= HDC_BUS_RDATA;
                end
                default: begin
                    bus_r <= HDC_BUS_IDLE;
                end
            endcase
        end
    end

    // one wait on reads so a write just before is always visible
    assign hreadyout = (bus_r != HDC_BUS_RWAIT);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign wr_stb    = (bus_r == HDC_BUS_WRITE);

    always_comb begin
        rd_val = 32'h0000_0000;
        case (idx_r)
            `HDC_IDX_CTRL:    rd_val[7:0] = ctrl_r;
            `HDC_IDX_MAN_LO:  rd_val[7:0] = man_lo_r;
            `HDC_IDX_TRIP_LO: rd_val[5:0] = trip_lo_r; // R13
            `HDC_IDX_TRIP_HI: rd_val[5:0] = trip_hi_r; // R13
            `HDC_IDX_STATUS:  rd_val[`HDC_ST_W-1:0] = status_r;
            `HDC_IDX_MASK:    rd_val[`HDC_ST_W-1:0] = mask_r;
            `HDC_IDX_CONFIG:  rd_val[0] = vtune_det_r;
            `HDC_IDX_MONITOR: begin
                rd_val[9:0]   = track_r; // R6
                rd_val[25:16] = dac_r;
                rd_val[28]    = hold_r;
                rd_val[29]    = locked;
            end
            default:          rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (bus_r == HDC_BUS_RWAIT) begin
            hrdata_r <= rd_val;
        end
    end

    // ---------------- configuration registers ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r   <= `HDC_CTRL_RESET; // R9
            man_lo_r <= `HDC_MAN_LO_RESET;
        end else if (wr_stb) begin
            if (idx_r == `HDC_IDX_CTRL) begin
                ctrl_r <= hwdata[7:0];
            end
            if (idx_r == `HDC_IDX_MAN_LO) begin
                man_lo_r <= hwdata[7:0]; // R10
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trip_lo_r   <= `HDC_TRIP_RESET;
            trip_hi_r   <= `HDC_TRIP_RESET;
            vtune_det_r <= 1'b0;
        end else if (wr_stb) begin
            if (idx_r == `HDC_IDX_TRIP_LO) begin
                trip_lo_r <= hwdata[5:0]; // R13
            end
            if (idx_r == `HDC_IDX_TRIP_HI) begin
                trip_hi_r <= hwdata[5:0]; // R13
            end
            if (idx_r == `HDC_IDX_CONFIG) begin
                vtune_det_r <= hwdata[0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_r <= '0;
        end else if (wr_stb && idx_r == `HDC_IDX_MASK) begin
            mask_r <= hwdata[`HDC_ST_W-1:0];
        end
    end

    // ---------------- analog status synchronisers ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_sync_r   <= 2'h0;
            cmp_sync_r    <= 2'h0;
            locked_prev_r <= 1'b0;
        end else begin
            lock_sync_r   <= {lock_sync_r[0], first_loop_locked};
            cmp_sync_r    <= {cmp_sync_r[0], vtune_above_dac};
            locked_prev_r <= lock_sync_r[1];
        end
    end

    assign locked = lock_sync_r[1];
    assign above  = cmp_sync_r[1];

    // ---------------- tuning DAC tracking ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tdiv_r <= '0;
        end else if (tdiv_r == TDIV_LAST) begin
            tdiv_r <= '0;
        end else begin
            tdiv_r <= tdiv_r + 1'b1;
        end
    end

    assign track_tick = (tdiv_r == TDIV_LAST);

    // independent of holdover so the code serves as a monitor
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            track_r <= `HDC_TRACK_RESET; // R4
        end else if (track_tick && ctrl_r[`HDC_CTRL_TRACK] && locked) begin
            if (above && track_r != `HDC_DAC_MAX) begin // R3 R5 R6
                track_r <= track_r + 1'b1;
            end else if (!above && track_r != `HDC_DAC_MIN) begin // R3 R5
                track_r <= track_r - 1'b1;
            end
        end
    end

    assign man_code = {ctrl_r[`HDC_CTRL_MAN_HI:0], man_lo_r}; // R10

    // ---------------- holdover and trip detection ----------------
    // tracked code stands for tuning voltage in 1/1024 of supply
    assign trip_lo = (track_r[9:4] <= trip_lo_r); // R11
    assign trip_hi = (~track_r[9:4] <= trip_hi_r); // R12
    assign hold_nxt = ctrl_r[`HDC_CTRL_FORCE] || // R7
                      (vtune_det_r && (trip_lo || trip_hi)); // R11 R12

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt; // R7
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_r <= `HDC_TRACK_RESET;
        end else if (hold_r && ctrl_r[`HDC_CTRL_MANUAL]) begin
            dac_r <= man_code; // R8 R9
        end else begin
            dac_r <= track_r; // R8
        end
    end

    assign dac_code        = dac_r;
    assign holdover_active = hold_r;

    // ---------------- signal-loss watchdogs ----------------
    always_comb begin
        case (ctrl_r[`HDC_CTRL_TMO_HI:`HDC_CTRL_TMO_LO]) // R1
            2'h0:    los_limit = `HDC_LOS_W'(`HDC_CYC(`HDC_LOS_T0_PS));
            2'h1:    los_limit = `HDC_LOS_W'(`HDC_CYC(`HDC_LOS_T1_PS));
            2'h2:    los_limit = `HDC_LOS_W'(`HDC_CYC(`HDC_LOS_T2_PS));
            default: los_limit = `HDC_LOS_W'(`HDC_CYC(`HDC_LOS_T3_PS));
        endcase
    end

    for (genvar g = 0; g < N_REF; g++) begin : g_los
        hdc_loss_detect #(
            .CNT_W   (`HDC_LOS_W)
        ) u_los (
            .hclk    (hclk),
            .hresetn (hresetn),
            .pin     (reference_input[g]),
            .enable  (ctrl_r[`HDC_CTRL_SIGNAL_LOSS_ENABLE] && ref_is_mos[g]), // R2
            .limit   (los_limit), // R1
            .lost    (loss_now[g])
        );
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loss_prev_r <= '0;
            switch_r    <= 1'b0;
        end else begin
            loss_prev_r <= loss_now;
            switch_r    <= switch_ev;
        end
    end

    assign switch_ev          = |(loss_now & ~loss_prev_r); // R1
    assign signal_loss        = loss_prev_r;
    assign clock_switch_event = switch_r;

    // ---------------- interrupt status ----------------
    always_comb begin
        ev_set                  = '0;
        ev_set[`HDC_ST_SWITCH]   = switch_ev;
        ev_set[`HDC_ST_HOLDOVER] = hold_nxt && !hold_r;
        ev_set[`HDC_ST_UNLOCK]   = locked_prev_r && !locked;
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r <= '0;
        end else if (wr_stb && idx_r == `HDC_IDX_STATUS) begin
            status_r <= (status_r & ~hwdata[`HDC_ST_W-1:0]) | ev_set;
        end else begin
            status_r <= status_r | ev_set;
        end
    end

    assign irq = |(status_r & mask_r);
endmodule

// file: verif/hdc_chk.sv
/*
 * Port-level assertions for hdc_top.
 * Assumes it is bound into hdc_top with the same parameters.
 */
module hdc_chk #(
    parameter int N_REF     = 3,
    parameter int TRACK_DIV = 508
) (
    input wire logic               hclk,
    input wire logic               hresetn,
    input wire logic               hsel,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic [N_REF-1:0]   ref_is_mos,
    input wire logic               first_loop_locked,
    input wire hdc_pkg::hdc_code_t dac_code,
    input wire logic               holdover_active,
    input wire logic [N_REF-1:0]   signal_loss,
    input wire logic               clock_switch_event
);
    timeunit 1ns;
    timeprecision 1ns;
    import hdc_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire req;
    assign req = hsel && hready && htrans[1];
    property p_reset_mid;
        $rose(hresetn) |-> dac_code == 10'h200;
    endproperty
    a_reset_mid: assert property (p_reset_mid)
        else $error("dac code not mid-scale after reset");
    property p_step;
        (!holdover_active [*3]) ##0 $changed(dac_code) |->
            (dac_code - $past(dac_code)) inside {10'h001, 10'h3ff};
    endproperty
    a_step: assert property (p_step)
        else $error("tracked code moved by more than one");
    property p_unlock;
        (!first_loop_locked && !holdover_active) [*6] |-> $stable(dac_code);
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("tracked code moved while unlocked");
    property p_switch;
        clock_switch_event |-> (signal_loss & ~$past(signal_loss)) != '0;
    endproperty
    a_switch: assert property (p_switch)
        else $error("switch event without new loss");
    property p_mos;
        (signal_loss & ~ref_is_mos) == '0;
    endproperty
    a_mos: assert property (p_mos)
        else $error("loss flagged on non-mos input");
    property p_rd_wait;
        (req && !hwrite) |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read data phase not one wait");
    property p_wr_nowait;
        (req && hwrite) |=> hreadyout;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait)
        else $error("write data phase stalled");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay)
        else $error("response not okay");
endmodule

bind hdc_top hdc_chk #(.N_REF(N_REF), .TRACK_DIV(TRACK_DIV)) u_chk (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .ref_is_mos, .first_loop_locked, .dac_code,
    .holdover_active, .signal_loss, .clock_switch_event
);

// file: verif/hdc_top_tb.sv
/*
 * Self-checking bench for hdc_top driven over AHB-Lite.
 * Assumes hdc_chk is bound in its own file; hready loops hreadyout.
 */
`include "hdc_consts.svh"
module hdc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import hdc_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [2:0]  ref_in = 3'h0;
    logic [2:0]  ref_is_mos = 3'h3;
    logic        locked = 1'b0;
    logic        above = 1'b1;
    logic        tog_en = 1'b0;
    logic        ph = 1'b0;
    logic [31:0] rd;
    logic [31:0] t1;
    wire         hreadyout;
    wire         hresp;
    wire [31:0]  hrdata;
    wire hdc_code_t dac_code;
    wire         holdover_active;
    wire [2:0]   signal_loss;
    wire         cse;
    wire         irq;
    int          err_count = 0;
    int          checks = 0;
    int          sw_cnt = 0;

    always #25 hclk = ~hclk;
    // pin edge every second cycle while enabled
    always @(posedge hclk) begin
        ph <= ~ph;
        if (ph)
            ref_in <= ref_in ^ {3{tog_en}};
    end
    // counts clock switch pulses
    always @(posedge hclk) begin
        if (cse === 1'b1)
            sw_cnt <= sw_cnt + 1;
    end

    hdc_top #(.TRACK_DIV(4)) u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .reference_input(ref_in), .ref_is_mos, .first_loop_locked(locked),
        .vtune_above_dac(above), .dac_code, .holdover_active, .signal_loss,
        .clock_switch_event(cse), .irq
    );

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ends on the edge where hready is sampled high
    task wt;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 20) begin
            err_count++;
            test_done;
        end
        rd = hrdata;
    endtask
    task xfer(input logic w, input logic [9:0] idx, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        wt;
        htrans <= 2'b00;
        hwdata <= d;
        wt;
    endtask
    task wr(input logic [9:0] i, input logic [31:0] d);
        xfer(1'b1, i, d);
    endtask
    task rdc(input logic [9:0] i, input logic [31:0] e);
        xfer(1'b0, i, 32'h0);
        chk(rd, e);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task t_reset;
        chk(dac_code, 32'h200);
        rdc(`HDC_IDX_CTRL, 32'h06);
        rdc(`HDC_IDX_MAN_LO, 32'h0);
        rdc(`HDC_IDX_TRIP_LO, 32'h0);
        rdc(`HDC_IDX_MONITOR, 32'h0200_0200);
        $display("t_reset done");
    endtask
    task t_regs;
        wr(`HDC_IDX_CTRL, 32'hffff_ffc3);
        rdc(`HDC_IDX_CTRL, 32'hc3);
        wr(`HDC_IDX_TRIP_LO, 32'hffff_ffff);
        rdc(`HDC_IDX_TRIP_LO, 32'h3f);
        wr(`HDC_IDX_TRIP_HI, 32'hffff_ffff);
        rdc(`HDC_IDX_TRIP_HI, 32'h3f);
        wr(10'h100, 32'hff);
        rdc(10'h100, 32'h0);
        wr(`HDC_IDX_MAN_LO, 32'hffff_ffff);
        rdc(`HDC_IDX_MAN_LO, 32'hff);
        $display("t_regs done");
    endtask
    task t_force;
        wr(`HDC_IDX_CTRL, 32'h0f);
        cyc(3);
        chk(holdover_active, 1'b1);
        chk(dac_code, 32'h3ff);
        wr(`HDC_IDX_CTRL, 32'h08);
        cyc(3);
        chk(dac_code, 32'h200);
        wr(`HDC_IDX_CTRL, 32'h04);
        cyc(3);
        chk(holdover_active, 1'b0);
        chk(dac_code, 32'h200);
        $display("t_force done");
    endtask
    task t_track;
        locked <= 1'b1;
        wr(`HDC_IDX_CTRL, 32'h18);
        cyc(40);
        xfer(1'b0, `HDC_IDX_MONITOR, 32'h0);
        chk(rd[9:0] > 10'h200, 1'b1);
        locked <= 1'b0;
        cyc(10);
        xfer(1'b0, `HDC_IDX_MONITOR, 32'h0);
        t1 = rd;
        cyc(20);
        rdc(`HDC_IDX_MONITOR, t1);
        locked <= 1'b1;
        above <= 1'b0;
        wr(`HDC_IDX_CTRL, 32'h04);
        xfer(1'b0, `HDC_IDX_MONITOR, 32'h0);
        t1 = rd;
        cyc(20);
        rdc(`HDC_IDX_MONITOR, t1);
        $display("t_track done");
    endtask
    // steady loss needs the pins to stop; edges every two cycles never trip
    task t_loss;
        rdc(`HDC_IDX_STATUS, 32'h6);
        tog_en <= 1'b1;
        wr(`HDC_IDX_MASK, 32'h1);
        wr(`HDC_IDX_CTRL, 32'he4);
        cyc(20);
        chk(signal_loss, 3'h0);
        chk(irq, 1'b0);
        tog_en <= 1'b0;
        cyc(5);
        chk(signal_loss, 3'h0);
        cyc(2);
        chk(signal_loss, 3'h3);
        chk(irq, 1'b1);
        tog_en <= 1'b1;
        wr(`HDC_IDX_CTRL, 32'h24);
        cyc(10);
        chk(signal_loss, 3'h0);
        tog_en <= 1'b0;
        cyc(8);
        chk(signal_loss, 3'h0);
        cyc(2);
        chk(signal_loss, 3'h3);
        wr(`HDC_IDX_CTRL, 32'h04);
        cyc(3);
        chk(signal_loss, 3'h0);
        chk(sw_cnt, 32'h2);
        wr(`HDC_IDX_MASK, 32'h0);
        cyc(2);
        chk(irq, 1'b0);
        wr(`HDC_IDX_STATUS, 32'h1);
        rdc(`HDC_IDX_STATUS, 32'h6);
        wr(`HDC_IDX_MASK, 32'h1);
        cyc(2);
        chk(irq, 1'b0);
        $display("t_loss done");
    endtask
    // tracked code sits just above mid-scale here, tracking off
    task t_trip;
        wr(`HDC_IDX_TRIP_LO, 32'h0);
        wr(`HDC_IDX_TRIP_HI, 32'h0);
        wr(`HDC_IDX_CONFIG, 32'h1);
        cyc(3);
        chk(holdover_active, 1'b0);
        wr(`HDC_IDX_TRIP_LO, 32'h20);
        cyc(3);
        chk(holdover_active, 1'b1);
        chk(dac_code, 32'h0ff);
        wr(`HDC_IDX_TRIP_LO, 32'h1f);
        cyc(3);
        chk(holdover_active, 1'b0);
        wr(`HDC_IDX_TRIP_HI, 32'h1f);
        cyc(3);
        chk(holdover_active, 1'b1);
        wr(`HDC_IDX_TRIP_HI, 32'h1e);
        cyc(3);
        chk(holdover_active, 1'b0);
        $display("t_trip done");
    endtask

    initial begin
        cyc(16);
        hresetn <= 1'b1;
        t_reset;
        t_regs;
        t_force;
        t_track;
        t_loss;
        t_trip;
        test_done;
    end
endmodule
